// ### src/afebe_pkg.sv
// package for the front-end block enable register bank
package afebe_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] FCFG_OFFSET = 32'h0000_2000;
  localparam logic [31:0] PMODE_OFFSET = 32'h0000_22f0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] FCFG_RESET = 32'h0008_0000;
  localparam logic [31:0] PMODE_RESET = 32'h0008_8800;

  // ---------------------------------------------------------------
  // frontend_config field layout
  // ---------------------------------------------------------------
  localparam int DC_DAC_BUF_BIT = 21;
  localparam int FAST_DAC_REF_BIT = 20;
  localparam int KEEP_ONE_BIT = 19;
  localparam int MAINS_NOTCH_BIT = 16;
  localparam int FOURIER_BIT = 15;
  localparam int WAVE_SYNTH_BIT = 14;
  localparam int LOWER_W = 14;
  localparam logic [31:0] FCFG_WMASK = 32'h0039_ffff;
  localparam logic [31:0] FCFG_RSVD_MASK = 32'hffc6_0000;
  localparam logic [31:0] PMODE_WMASK = 32'hffff_ffff;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } afebe_wb_req_t;

  typedef struct packed {
    logic dc_dac_buffer_enable;
    logic fast_dac_reference_enable;
    logic mains_notch_enable;
    logic fourier_engine_enable;
    logic wave_synth_enable;
  } afebe_enables_t;

  // byte-lane merge of write data into a register under a write mask
  function automatic logic [31:0] afebe_merge(input logic [31:0] old_v,
                                              input logic [31:0] wr_v,
                                              input logic [3:0] sel,
                                              input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    afebe_merge = (old_v & ~(lane & wmask)) | (wr_v & lane & wmask);
  endfunction : afebe_merge

endpackage : afebe_pkg

// ### src/afebe_regs.sv
// wishbone register bank holding the front-end block enables and power mode
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// - frontend_config sits at 0x00002000, resets to 0x00080000, readable and writable.
// - power_mode_config sits at 0x000022f0, resets to 0x00088800, readable and writable.
// - bit 21 set powers the dc DAC buffer; clear disables; resets 0.
// - bit 20 set enables fast DAC reference; clear disables; resets 0.
// - bit 19 resets to one; software keeps it one on every write.
// - bit 16 puts the mains notch filter in the ADC path; resets 0.
// - bit 15 enables the Fourier engine; resets 0.
// - bit 14 enables the wave synthesiser, sine and trapezoid; resets 0.
module afebe_regs #(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire afebe_pkg::afebe_wb_req_t wb_req_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output afebe_pkg::afebe_enables_t enables_out,
  output logic [afebe_pkg::LOWER_W-1:0] frontend_lower_out,
  output logic [31:0] power_mode_config_out
);
  import afebe_pkg::*;

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
    $error("afebe_regs: ADDR_W must lie between 14 and 32");
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [31:0] frontend_config_r;
  logic [31:0] power_mode_config_r;
  logic ack_r;
  logic [31:0] rdat_r;
  wire logic [31:0] addr_mask = 32'hffff_ffff >> (32 - ADDR_W);
  wire logic [31:0] adr_full = wb_req_in.adr & addr_mask;
  wire logic req_live = wb_req_in.cyc & wb_req_in.stb;
  wire logic hit_fcfg = (adr_full[31:2] == FCFG_OFFSET[31:2]);
  wire logic hit_pmode = (adr_full[31:2] == PMODE_OFFSET[31:2]);
  wire logic wr_commit = req_live & ack_r & wb_req_in.we;
  wire logic [31:0] fcfg_nxt = afebe_merge(frontend_config_r, wb_req_in.dat, wb_req_in.sel,
                                           FCFG_WMASK);
  wire logic [31:0] pmode_nxt = afebe_merge(power_mode_config_r, wb_req_in.dat,
                                            wb_req_in.sel, PMODE_WMASK);
  wire logic [31:0] rd_sel = hit_fcfg ? (frontend_config_r & ~FCFG_RSVD_MASK) :
                             hit_pmode ? power_mode_config_r : 32'h0000_0000;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req_live & ~ack_r;
      if (req_live & ~ack_r) begin
        rdat_r <= rd_sel;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frontend_config_r <= FCFG_RESET;
      power_mode_config_r <= PMODE_RESET;
    end else begin
      if (wr_commit & hit_fcfg) begin
        frontend_config_r <= fcfg_nxt;
      end
      if (wr_commit & hit_pmode) begin
        power_mode_config_r <= pmode_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;
  assign enables_out.dc_dac_buffer_enable = frontend_config_r[DC_DAC_BUF_BIT];
  assign enables_out.fast_dac_reference_enable = frontend_config_r[FAST_DAC_REF_BIT];
  assign enables_out.mains_notch_enable = frontend_config_r[MAINS_NOTCH_BIT];
  assign enables_out.fourier_engine_enable = frontend_config_r[FOURIER_BIT];
  assign enables_out.wave_synth_enable = frontend_config_r[WAVE_SYNTH_BIT];
  assign frontend_lower_out = frontend_config_r[LOWER_W-1:0];
  assign power_mode_config_out = power_mode_config_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  wire logic fcfg_wr = wr_commit & hit_fcfg;

  reset_values_a: assert property (
    @(posedge ref_clk_in) $rose(rst_n_in) |->
      frontend_config_r == FCFG_RESET && power_mode_config_r == PMODE_RESET)
    else $error("reset values wrong");

  keep_one_rst_a: assert property (
    @(posedge ref_clk_in) $rose(rst_n_in) |-> frontend_config_r[KEEP_ONE_BIT] &&
      !enables_out.dc_dac_buffer_enable && !enables_out.wave_synth_enable)
    else $error("bit 19 or enables wrong after reset");

  pmode_write_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      wr_commit && hit_pmode && wb_req_in.sel == 4'hf |=>
      power_mode_config_out == $past(wb_req_in.dat))
    else $error("power mode write not stored");

  dac_buf_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel[2] |=>
      enables_out.dc_dac_buffer_enable == $past(wb_req_in.dat[DC_DAC_BUF_BIT]))
    else $error("dc dac buffer enable not updated");

  dac_ref_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel[2] |=>
      enables_out.fast_dac_reference_enable == $past(wb_req_in.dat[FAST_DAC_REF_BIT]))
    else $error("dac reference enable not updated");

  notch_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel[2] |=>
      enables_out.mains_notch_enable == $past(wb_req_in.dat[MAINS_NOTCH_BIT]))
    else $error("notch enable not updated");

  fourier_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel[1] |=>
      enables_out.fourier_engine_enable == $past(wb_req_in.dat[FOURIER_BIT]))
    else $error("fourier enable not updated");

  wave_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel[1] |=>
      enables_out.wave_synth_enable == $past(wb_req_in.dat[WAVE_SYNTH_BIT]))
    else $error("wave synth enable not updated");

  rsvd_read_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ack_r && !wb_req_in.we && hit_fcfg |->
      (wb_dat_out & FCFG_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  fcfg_read_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      req_live && !ack_r && !wb_req_in.we && hit_fcfg |=>
      wb_ack_out && wb_dat_out == (frontend_config_r & ~FCFG_RSVD_MASK))
    else $error("frontend config read wrong");

  ack_pulse_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  rsvd_zero_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (frontend_config_r & FCFG_RSVD_MASK) == 32'h0000_0000)
    else $error("reserved frontend bits stored nonzero");

  ack_latency_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      req_live && !ack_r |=> wb_ack_out)
    else $error("ack not given one cycle after request");

  idle_no_ack_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !req_live |=> !wb_ack_out)
    else $error("ack without request");

  fcfg_hold_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !fcfg_wr |=> $stable(frontend_config_r))
    else $error("frontend config changed without write");

  pmode_hold_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !(wr_commit && hit_pmode) |=> $stable(power_mode_config_r))
    else $error("power mode changed without write");

  fcfg_lane_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && !wb_req_in.sel[2] |=> $stable(frontend_config_r[23:16]))
    else $error("unselected byte lane changed");

  keep_one_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel[2] |=>
      frontend_config_r[KEEP_ONE_BIT] == $past(wb_req_in.dat[KEEP_ONE_BIT]))
    else $error("bit 19 not stored as written");

  unmapped_read_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ack_r && !wb_req_in.we && !hit_fcfg && !hit_pmode |-> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read nonzero");

  pmode_read_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      req_live && !ack_r && !wb_req_in.we && hit_pmode |=>
      wb_ack_out && wb_dat_out == $past(power_mode_config_r))
    else $error("power mode read wrong");

  lower_wr_a: assert property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      fcfg_wr && wb_req_in.sel == 4'hf |=>
      frontend_lower_out == $past(wb_req_in.dat[LOWER_W-1:0]))
    else $error("lower frontend bits not stored");

  enables_rst_a: assert property (
    @(posedge ref_clk_in) $rose(rst_n_in) |->
      enables_out == '0 && frontend_lower_out == '0)
    else $error("enables not clear after reset");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  fcfg_write_c: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in) fcfg_wr);
  pmode_write_c: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in) wr_commit && hit_pmode);
  unmapped_c: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in) ack_r && !hit_fcfg && !hit_pmode);
  all_on_c: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in) &enables_out);
  notch_set_c: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in) fcfg_wr && wb_req_in.dat[MAINS_NOTCH_BIT]);

endmodule : afebe_regs

// ### tb/afebe_regs_tb_top.sv
// self-checking bench for the front-end enable register bank
`timescale 1ns/1ps
module afebe_regs_tb_top;
  import afebe_pkg::*;
  // ---------------------------------------------------------------
  // signals and instance
  // ---------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  afebe_wb_req_t wb_req_in = '0;
  logic wb_ack_out;
  logic [31:0] wb_dat_out;
  afebe_enables_t enables_out;
  logic [LOWER_W-1:0] frontend_lower_out;
  logic [31:0] power_mode_config_out;
  logic [31:0] fm;
  logic [31:0] pm;
  logic [31:0] q;
  logic [31:0] d;
  logic [31:0] a;
  logic [3:0] s;
  integer seed = 32'h6ab96a82;
  int fails = 0;
  int n_tests = 0;
  afebe_regs u_afebe_regs (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .enables_out(enables_out), .frontend_lower_out(frontend_lower_out),
    .power_mode_config_out(power_mode_config_out));
  always #10 ref_clk_in = ~ref_clk_in;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] mrg(input logic [31:0] o, w, input logic [3:0] l,
                                      input logic [31:0] m);
    logic [31:0] k;
    k = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}} & m;
    return (o & ~k) | (w & k);
  endfunction : mrg
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [31:0] ad, dt, input logic [3:0] sl);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sl, adr: ad, dat: dt};
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_req_in <= '0;
    chk(n, 32'h0000_0002);
    @(posedge ref_clk_in);
    chk({31'h0, wb_ack_out}, 32'h0000_0000);
    if (we && ad == FCFG_OFFSET) fm = mrg(fm, dt, sl, FCFG_WMASK);
    if (we && ad == PMODE_OFFSET) pm = mrg(pm, dt, sl, PMODE_WMASK);
  endtask : wb
  task automatic outs();
    @(posedge ref_clk_in);
    chk({27'h0, enables_out}, {27'h0, fm[21], fm[20], fm[16], fm[15], fm[14]});
    chk({18'h0, frontend_lower_out}, {18'h0, fm[13:0]});
    chk(power_mode_config_out, pm);
    wb(1'b0, 32'h0000_2000, 32'h0, 4'hf);
    chk(q, fm);
    wb(1'b0, 32'h0000_22f0, 32'h0, 4'hf);
    chk(q, pm);
  endtask : outs
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    fm = 32'h0008_0000;
    pm = 32'h0008_8800;
    repeat (4) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    outs();
    wb(1'b1, 32'h0000_2000, 32'hffff_ffff, 4'hf);
    outs();
    wb(1'b1, 32'h0000_2000, 32'h0008_0000, 4'hf);
    outs();
    wb(1'b1, FCFG_OFFSET, 32'h0038_c000, 4'hf);
    outs();
    wb(1'b1, 32'h0000_2004, 32'hffff_ffff, 4'hf);
    chk(q, 32'h0);
    outs();
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      s = $random(seed);
      a = {$random(seed)} % 3 == 0 ? 32'h0000_2000 : (i % 2 ? 32'h0000_22f0 : 32'h0000_2008);
      if (a == 32'h0000_2000) d[19] = 1'b1;
      if (a == FCFG_OFFSET && d[15]) d[16] = 1'b0;
      wb(1'b1, a, d, s);
      if (a == 32'h0000_2008) chk(q, 32'h0);
      outs();
    end
    rst_n_in <= 1'b0;
    fm = 32'h0008_0000;
    pm = 32'h0008_8800;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    outs();
    close_out();
  end
  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule : afebe_regs_tb_top
